// File: rtl/reset_seq_pkg.sv
// Constants and types for the reset pin state sequencer
// Operation
// - Hold processor reset low, release 1 ms later
// - Drive address lines low when straps say
// - Release strapped address lines two clocks later
// - Drive bus request zero until two clocks after
// - Hold DRAM clock enable low 256 clocks
// - Command clocks low in reset, then toggle
// - Park strobes, chip selects; tri-state data lines
// - DRAM address and bank either level allowed
// - Hub lane sixteen pull by swizzle, then low
// - Reset input clears logic asynchronously
// - Power good resets everything including sticky state
package reset_seq_pkg;
  // ****************************************
  // Timing and widths
  // ****************************************
  localparam int CLK_FREQ_HZ = 250000000;
  localparam int CPU_RESET_EXT_US = 1000;
  localparam int CPU_RESET_EXT_CYCLES = (CLK_FREQ_HZ / 1000000) * CPU_RESET_EXT_US;
  localparam int RELEASE_DELAY_CLKS = 2;
  localparam int CKE_DELAY_CLKS = 256;
  localparam int ADDR_WIDTH = 33;
  localparam int DRAM_ADDR_WIDTH = 13;
  localparam int CHECK_WIDTH = 8;
  localparam int CMD_CLK_WIDTH = 4;
  localparam int CS_WIDTH = 8;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    ST_IN_RESET = 3'h0,
    ST_EXTEND = 3'h1,
    ST_RELEASE_WAIT = 3'h2,
    ST_RUN = 3'h3
  } seq_state_t;

  typedef struct packed {
    logic [CMD_CLK_WIDTH-1:0] cmd_clk;
    logic [CMD_CLK_WIDTH-1:0] cmd_clk_n;
    logic clock_enable;
    logic row_strobe_n;
    logic column_strobe_n;
    logic write_enable_n;
    logic [CS_WIDTH-1:0] chip_select_n;
    logic [DRAM_ADDR_WIDTH-1:0] dram_address_out;
    logic [1:0] bank_select;
    logic data_oe;
    logic [CHECK_WIDTH-1:0] dram_check_bits_oe;
  } dram_pins_t;
endpackage

// File: rtl/reset_pin_state_sequencer.sv
// Pin state sequencer for reset entry and release
`timescale 1ns/100ps
module reset_pin_state_sequencer #(
  parameter int EXT_CYCLES = reset_seq_pkg::CPU_RESET_EXT_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic reset_input_n,
  input wire logic power_good_in,
  input wire logic [reset_seq_pkg::ADDR_WIDTH-1:0] power_on_config,
  input wire logic lane_swizzle,
  output logic processor_reset_out_n,
  output logic processor_reset_oe,
  output logic [reset_seq_pkg::ADDR_WIDTH-1:0] host_address_lines,
  output logic [reset_seq_pkg::ADDR_WIDTH-1:0] host_address_oe,
  output logic bus_request_zero_n,
  output logic bus_request_zero_oe,
  output reset_seq_pkg::dram_pins_t dram_a,
  output reset_seq_pkg::dram_pins_t dram_b,
  output logic hub_lane_sixteen_pull_up,
  output logic hub_lane_sixteen_pull_down,
  output logic hub_lane_sixteen_term_low
);
  import reset_seq_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  localparam int CHANNELS = 2;

  logic any_reset;
  seq_state_t state;
  logic [31:0] count;
  logic [8:0] cke_count;
  logic cmd_phase;
  logic [ADDR_WIDTH-1:0] strap_low;
  logic cke_on;
  logic cpu_released;
  logic breq_hold;
  logic [ADDR_WIDTH-1:0] addr_drive_low;
  dram_pins_t channel_pins [CHANNELS];

  // ****************************************
  // Reset combine
  // ****************************************
  // Power good clears all state, sticky straps too
  assign any_reset = rst | ~power_good_in | ~reset_input_n;

  // ****************************************
  // Sequence
  // ****************************************
  always_ff @(posedge ref_clk or negedge reset_input_n) begin
    if (!reset_input_n || rst || !power_good_in) begin
      state <= ST_IN_RESET;
      count <= 32'h0;
    end else begin
      case (state)
        ST_IN_RESET: begin
          state <= ST_EXTEND;
          count <= 32'h0;
        end
        ST_EXTEND: begin
          if (count >= 32'(EXT_CYCLES - 1)) begin
            state <= ST_RELEASE_WAIT;
            count <= 32'h0;
          end else begin
            count <= count + 32'h1;
          end
        end
        ST_RELEASE_WAIT: begin
          if (count >= 32'(RELEASE_DELAY_CLKS - 1)) begin
            state <= ST_RUN;
          end else begin
            count <= count + 32'h1;
          end
        end
        ST_RUN: state <= ST_RUN;
        default: state <= ST_IN_RESET;
      endcase
    end
  end

  // ****************************************
  // Strap capture
  // ****************************************
  // Strap capture while reset held
  always_ff @(posedge ref_clk) begin
    if (rst || !power_good_in) begin
      strap_low <= '0;
    end else if (!reset_input_n) begin
      strap_low <= power_on_config;
    end
  end

  // ****************************************
  // Clock enable
  // ****************************************
  // Clock enable delay
  always_ff @(posedge ref_clk or negedge reset_input_n) begin
    if (!reset_input_n || rst || !power_good_in) begin
      cke_count <= 9'h0;
      cke_on <= 1'b0;
    end else if (cke_count >= 9'(CKE_DELAY_CLKS - 1)) begin
      cke_on <= 1'b1;
    end else begin
      cke_count <= cke_count + 9'h1;
    end
  end

  // ****************************************
  // Command clock
  // ****************************************
  // Command clock divider
  always_ff @(posedge ref_clk or negedge reset_input_n) begin
    if (!reset_input_n || rst || !power_good_in) begin
      cmd_phase <= 1'b0;
    end else begin
      cmd_phase <= ~cmd_phase;
    end
  end

  // ****************************************
  // Pin drive
  // ****************************************
  // Processor reset released once the extension ends
  always_comb begin
    cpu_released = (state == ST_RELEASE_WAIT) || (state == ST_RUN);
    processor_reset_out_n = cpu_released;
    processor_reset_oe = ~cpu_released;
  end

  // Bus request zero held from reset deassertion until run
  always_comb begin
    breq_hold = ~any_reset && (state != ST_RUN);
    bus_request_zero_n = 1'b0;
    bus_request_zero_oe = breq_hold;
  end

  // ****************************************
  // Host address lines
  // ****************************************
  // Drive decision for one strapped address line
  function automatic logic line_drive(input seq_state_t st, input logic in_reset, input logic cfg, input logic held);
    logic drive;
    drive = 1'b0;
    if (st == ST_RUN) begin
      drive = 1'b0;
    end else if (in_reset) begin
      drive = cfg;
    end else begin
      drive = held;
    end
    return drive;
  endfunction

  // One drive decision per address line
  genvar line;
  generate
    for (line = 0; line < ADDR_WIDTH; line++) begin : g_addr_line
      assign addr_drive_low[line] = line_drive(state, any_reset, power_on_config[line], strap_low[line]);
    end
  endgenerate

  assign host_address_lines = '0;
  assign host_address_oe = addr_drive_low;

  // ****************************************
  // Hub lane sixteen
  // ****************************************
  // Weak pull by swizzle strap in reset, then low termination
  always_comb begin
    hub_lane_sixteen_pull_up = any_reset && lane_swizzle;
    hub_lane_sixteen_pull_down = any_reset && !lane_swizzle;
    hub_lane_sixteen_term_low = ~any_reset;
  end

  // ****************************************
  // DRAM pin parking
  // ****************************************

  // DRAM pins, both channels
  function automatic dram_pins_t park_dram(input logic phase, input logic cke);
    dram_pins_t p;
    p.cmd_clk = {CMD_CLK_WIDTH{phase}};
    p.cmd_clk_n = '0;
    p.clock_enable = cke;
    p.row_strobe_n = 1'b0;
    p.column_strobe_n = 1'b1;
    p.write_enable_n = 1'b1;
    p.chip_select_n = '1;
    p.dram_address_out = '0;
    p.bank_select = 2'h0;
    p.data_oe = 1'b0;
    p.dram_check_bits_oe = '0;
    return p;
  endfunction

  // ****************************************
  // Run marker
  // ****************************************
  // Complement clock stays low until the second edge after release
  logic started;
  always_ff @(posedge ref_clk or negedge reset_input_n) begin
    if (!reset_input_n || rst || !power_good_in) begin
      started <= 1'b0;
    end else begin
      started <= 1'b1;
    end
  end

  // ****************************************
  // DRAM channels
  // ****************************************
  // Both channels park identically
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_channel
      always_comb begin
        channel_pins[ch] = park_dram(cmd_phase, cke_on);
        channel_pins[ch].cmd_clk_n = started ? {CMD_CLK_WIDTH{~cmd_phase}} : '0;
      end
    end
  endgenerate

  assign dram_a = channel_pins[0];
  assign dram_b = channel_pins[1];
endmodule

// File: verification/host_bus_term.sv
// Far side terminations of the processor bus lines
`timescale 1ns/100ps
module host_bus_term (
  input wire logic processor_reset_out_n,
  input wire logic processor_reset_oe,
  input wire logic [reset_seq_pkg::ADDR_WIDTH-1:0] host_address_lines,
  input wire logic [reset_seq_pkg::ADDR_WIDTH-1:0] host_address_oe,
  input wire logic bus_request_zero_n,
  input wire logic bus_request_zero_oe,
  output logic cpu_w,
  output logic [reset_seq_pkg::ADDR_WIDTH-1:0] addr_w,
  output logic breq_w
);
  // Released lines sit at the terminated high level
  assign cpu_w = processor_reset_oe ? processor_reset_out_n : 1'b1;
  assign addr_w = (host_address_lines & host_address_oe) | ~host_address_oe;
  assign breq_w = bus_request_zero_oe ? bus_request_zero_n : 1'b1;
endmodule

// File: verification/rps_sva.sv
// Assertions for the reset pin state sequencer
`timescale 1ns/100ps
module rps_sva (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic reset_input_n,
  input wire logic power_good_in,
  input wire logic lane_swizzle,
  input wire logic processor_reset_out_n,
  input wire logic [reset_seq_pkg::ADDR_WIDTH-1:0] host_address_oe,
  input wire logic bus_request_zero_oe,
  input wire reset_seq_pkg::dram_pins_t dram_a,
  input wire reset_seq_pkg::dram_pins_t dram_b,
  input wire logic hub_lane_sixteen_pull_up
);
  import reset_seq_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst || !power_good_in);
  property p_a; !reset_input_n |-> !processor_reset_out_n; endproperty
  property p_b; $rose(processor_reset_out_n) |-> ##2 host_address_oe == '0; endproperty
  property p_c; $rose(processor_reset_out_n) |-> bus_request_zero_oe; endproperty
  property p_d; !reset_input_n |-> !dram_a.clock_enable && !dram_b.clock_enable; endproperty
  property p_e; !reset_input_n |-> dram_a.cmd_clk == '0 && dram_b.cmd_clk_n == '0; endproperty
  property p_f; reset_input_n && $past(reset_input_n, 3) |-> dram_b.cmd_clk != $past(dram_b.cmd_clk); endproperty
  property p_g; {dram_a.row_strobe_n, dram_a.write_enable_n, dram_a.data_oe} == 3'h2; endproperty
  property p_h; !reset_input_n && !$past(reset_input_n) |-> hub_lane_sixteen_pull_up == lane_swizzle; endproperty
  a_a: assert property (p_a) else $error("cpu reset high in reset");
  a_b: assert property (p_b) else $error("address lines held");
  a_c: assert property (p_c) else $error("bus request released early");
  a_d: assert property (p_d) else $error("clock enable high in reset");
  a_e: assert property (p_e) else $error("command clock runs in reset");
  a_f: assert property (p_f) else $error("command clock stuck");
  a_g: assert property (p_g) else $error("strobes not parked");
  a_h: assert property (p_h) else $error("lane pull wrong");
  c_a: cover property ($rose(processor_reset_out_n));
  c_b: cover property ($rose(dram_a.clock_enable));
  c_c: cover property (!reset_input_n && lane_swizzle);
endmodule
bind reset_pin_state_sequencer rps_sva i_sva (.*);

// File: verification/reset_pin_state_sequencer_test.sv
// Testbench for the reset pin state sequencer
`timescale 1ns/100ps
module reset_pin_state_sequencer_test;
  import reset_seq_pkg::*;
  logic ref_clk = 0, rst = 1, reset_input_n = 0, power_good_in = 1, lane_swizzle = 0;
  logic [32:0] power_on_config = '0, host_address_lines, host_address_oe, addr_w;
  logic processor_reset_out_n, processor_reset_oe, bus_request_zero_n, bus_request_zero_oe;
  logic hub_lane_sixteen_pull_up, hub_lane_sixteen_pull_down, hub_lane_sixteen_term_low;
  logic cpu_w, breq_w, prev_cpu = 0, prev_cke = 0;
  dram_pins_t dram_a, dram_b;
  int n_errors = 0, n_checks = 0, cnt = 0, q[$];
  logic [31:0] seed = 32'h1a;
  reset_pin_state_sequencer #(.EXT_CYCLES(20)) i_dut (.*);
  host_bus_term i_far (.*);
  always #2 ref_clk = ~ref_clk;
  function logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  task chk(logic [63:0] seen, logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task end_sim;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge ref_clk) cnt <= reset_input_n ? cnt + 1 : 0;
  // Monitor takes the oldest note when a release shows
  always @(negedge ref_clk) begin
    if (cpu_w && !prev_cpu) chk(cnt, q.pop_front());
    if (dram_a.clock_enable && !prev_cke) chk(cnt, q.pop_front());
    if (cnt == 22) chk({addr_w, breq_w}, {~power_on_config, 1'b0});
    if (cnt == 23) chk({addr_w, breq_w, hub_lane_sixteen_term_low}, {35{1'b1}});
    prev_cpu <= cpu_w;
    prev_cke <= dram_a.clock_enable;
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 0;
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      @(posedge ref_clk);
      reset_input_n <= 0;
      power_on_config <= {seed, seed[3]};
      lane_swizzle <= seed[7];
      power_good_in <= (i != 2);
      #1 chk(cpu_w, 0);
      repeat (4) @(posedge ref_clk);
      power_good_in <= 1;
      #1 chk({addr_w, hub_lane_sixteen_pull_up, hub_lane_sixteen_pull_down}, {~power_on_config, lane_swizzle, ~lane_swizzle});
      q.push_back(21);
      q.push_back(256);
      @(posedge ref_clk) reset_input_n <= 1;
      repeat (262) @(posedge ref_clk);
    end
    end_sim;
  end
  initial begin
    #8000;
    n_errors++;
    end_sim;
  end
endmodule
